// *** rtl/op_decode_pkg.sv ***
`default_nettype none
package op_decode_pkg;
    // instruction word layout
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int D_BIT = 5;
    // opcode matches (upper bits of the word)
    localparam logic [5:0] INC_SKIP_PAT = 6'h0F;  // 0011 11
    localparam logic [5:0] OR_FILE_PAT = 6'h04;   // 0001 00
    localparam logic [3:0] OR_LIT_PAT = 4'hD;     // 1101
    // values after reset
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FADDR_RESET = 5'h00;
    // operation classes
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_INC_SKIP = 2'b01,
        OP_OR_FILE = 2'b11,
        OP_OR_LIT = 2'b10
    } op_class_t;
endpackage
`default_nettype wire

// *** rtl/op_classifier.sv ***
`timescale 1ns/1ps
`default_nettype none
// sorts one instruction word into an operation class
module op_classifier (
    // instruction word
    input wire logic [11:0] insn_in,
    // class result
    output var op_decode_pkg::op_class_t class_out
);
    // match the fixed opcode bits
    always_comb
    begin
        if (insn_in[11:6] == op_decode_pkg::INC_SKIP_PAT)
            class_out = op_decode_pkg::OP_INC_SKIP;
        else if (insn_in[11:6] == op_decode_pkg::OR_FILE_PAT)
            class_out = op_decode_pkg::OP_OR_FILE;
        else if (insn_in[11:8] == op_decode_pkg::OR_LIT_PAT)
            class_out = op_decode_pkg::OP_OR_LIT;
        else
            class_out = op_decode_pkg::OP_NONE;
    end
endmodule
`default_nettype wire

// *** rtl/incr_skip_and_or_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - increment file register, result to accumulator or file by d, flags kept
// - zero increment result discards fetched next instruction, runs a no-op instead
// - or literal: accumulator OR 8-bit literal into accumulator, zero flag, one cycle
// - or file: accumulator OR file register to accumulator or file by d
module incr_skip_and_or_exec (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // instruction from fetch stage
    input wire logic insn_valid_in,
    input wire logic [11:0] insn_in,
    // register file read data for the addressed file
    input wire logic [7:0] file_rdata_in,
    // zero flag value held by the core
    input wire logic zero_flag_in,
    // register file read address, combinational from the current word
    output logic [4:0] file_raddr_out,
    // register file write port
    output logic file_we_out,
    output logic [4:0] file_waddr_out,
    output logic [7:0] file_wdata_out,
    // accumulator
    output logic [7:0] acc_out,
    // zero flag update
    output logic zero_we_out,
    output logic zero_flag_out,
    // fetch pipeline: flush pulse and no-op cycle marker
    output logic flush_out,
    output logic nop_cycle_out
);
    op_decode_pkg::op_class_t op_class;

    typedef struct packed {
        logic [7:0] acc;
        logic file_we;
        logic [4:0] file_waddr;
        logic [7:0] file_wdata;
        logic zero_we;
        logic zero_flag;
        logic flush;
        logic skip;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [7:0] sum;
    logic [7:0] orv;

    op_classifier u_class (
        .insn_in(insn_in),
        .class_out(op_class)
    );

    // read address taken straight from the word (file not a registered output)
    assign file_raddr_out = insn_in[4:0];

    // datapath results
    always_comb
    begin
        sum = file_rdata_in + 8'h01;
        if (op_class == op_decode_pkg::OP_OR_LIT)
            orv = st_r.acc | insn_in[7:0];
        else
            orv = st_r.acc | file_rdata_in;
    end

    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.file_we = 1'b0;
        st_nxt.zero_we = 1'b0;
        st_nxt.flush = 1'b0;
        // a pending skip waits for the next valid word, so a fetch bubble cannot absorb it
        st_nxt.skip = st_r.skip && !insn_valid_in;
        st_nxt.zero_flag = zero_flag_in;
        st_nxt.file_waddr = insn_in[4:0];
        if (st_r.skip)
        begin
            // discarded word executes as a no-op
        end
        else if (insn_valid_in)
        begin
            case (op_class)
                op_decode_pkg::OP_INC_SKIP:
                begin
                    if (insn_in[op_decode_pkg::D_BIT])
                    begin
                        st_nxt.file_we = 1'b1;
                        st_nxt.file_wdata = sum;
                    end
                    else
                        st_nxt.acc = sum;
                    if (sum == 8'h00)
                    begin
                        st_nxt.flush = 1'b1;
                        st_nxt.skip = 1'b1;
                    end
                end
                op_decode_pkg::OP_OR_LIT:
                begin
                    st_nxt.acc = orv;
                    st_nxt.zero_we = 1'b1;
                    st_nxt.zero_flag = (orv == 8'h00);
                end
                op_decode_pkg::OP_OR_FILE:
                begin
                    if (insn_in[op_decode_pkg::D_BIT])
                    begin
                        st_nxt.file_we = 1'b1;
                        st_nxt.file_wdata = orv;
                    end
                    else
                        st_nxt.acc = orv;
                    st_nxt.zero_we = 1'b1;
                    st_nxt.zero_flag = (orv == 8'h00);
                end
                default:
                begin
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_r <= '0;
            st_r.acc <= op_decode_pkg::ACC_RESET;
            st_r.file_waddr <= op_decode_pkg::FADDR_RESET;
        end
        else
            st_r <= st_nxt;
    end

    assign acc_out = st_r.acc;
    assign file_we_out = st_r.file_we;
    assign file_waddr_out = st_r.file_waddr;
    assign file_wdata_out = st_r.file_wdata;
    assign zero_we_out = st_r.zero_we;
    assign zero_flag_out = st_r.zero_flag;
    assign flush_out = st_r.flush;
    assign nop_cycle_out = st_r.skip;

    // checks on the increment-and-skip path
    a_inc_no_flags: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_INC_SKIP)
        |=> !zero_we_out)
        else $error("increment touched zero flag");
    a_inc_file_sum: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_INC_SKIP
        && insn_in[op_decode_pkg::D_BIT])
        |=> file_we_out && file_wdata_out == $past(file_rdata_in) + 8'h01)
        else $error("increment to file wrong");
    a_inc_acc_sum: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_INC_SKIP
        && !insn_in[op_decode_pkg::D_BIT])
        |=> !file_we_out && acc_out == $past(file_rdata_in) + 8'h01)
        else $error("increment to accumulator wrong");
    a_skip_flush: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_INC_SKIP
        && file_rdata_in == 8'hFF) |=> flush_out ##1 !file_we_out && !zero_we_out)
        else $error("zero increment did not skip");
    a_no_skip_nonzero: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_INC_SKIP
        && file_rdata_in != 8'hFF) |=> !flush_out)
        else $error("skip on nonzero result");
    a_skip_nop_mark: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        flush_out |-> nop_cycle_out)
        else $error("flush without no-op slot");
    a_skip_drops_word: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (nop_cycle_out && insn_valid_in)
        |=> !file_we_out && !zero_we_out && !flush_out && !nop_cycle_out
        && acc_out == $past(acc_out))
        else $error("skipped word took effect");
    // checks on the two or operations
    a_or_lit_acc: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_OR_LIT)
        |=> acc_out == ($past(acc_out) | $past(insn_in[7:0])) && zero_we_out)
        else $error("or literal wrong");
    a_or_file_dest: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_OR_FILE
        && !insn_in[op_decode_pkg::D_BIT])
        |=> acc_out == ($past(acc_out) | $past(file_rdata_in)) && !file_we_out)
        else $error("or file to accumulator wrong");
    a_or_file_wr: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_OR_FILE
        && insn_in[op_decode_pkg::D_BIT])
        |=> file_we_out && acc_out == $past(acc_out))
        else $error("or file to file wrong");
    a_or_file_data: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (insn_valid_in && !st_r.skip && op_class == op_decode_pkg::OP_OR_FILE
        && insn_in[op_decode_pkg::D_BIT])
        |=> file_wdata_out == ($past(acc_out) | $past(file_rdata_in))
        && file_waddr_out == $past(insn_in[4:0]))
        else $error("or file write data wrong");
    // zero flag follows whichever result was written
    a_zero_value: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        zero_we_out |-> zero_flag_out == ((file_we_out ? file_wdata_out : acc_out) == 8'h00))
        else $error("zero flag mismatch");
    // scenarios worth seeing
    c_skip: cover property (@(posedge clock_in) disable iff (!reset_n_in) flush_out);
    c_skip_drop: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        nop_cycle_out && insn_valid_in);
    c_or_lit: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        zero_we_out && !file_we_out);
    c_or_file: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        zero_we_out && file_we_out);
endmodule
`default_nettype wire

// *** sim/tb_incr_skip_and_or_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_incr_skip_and_or_exec;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic valid = 1'b0;
    logic [11:0] insn = 12'h000;
    logic [7:0] rdata = 8'h00;
    logic zf_in = 1'b0;
    logic [4:0] raddr, waddr;
    logic we, zwe, zf, flush, nop;
    logic [7:0] wdata, acc;
    int err_count = 0;
    int n_checks = 0;
    incr_skip_and_or_exec dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .insn_valid_in(valid), .insn_in(insn), .file_rdata_in(rdata), .zero_flag_in(zf_in),
        .file_raddr_out(raddr), .file_we_out(we), .file_waddr_out(waddr),
        .file_wdata_out(wdata), .acc_out(acc), .zero_we_out(zwe), .zero_flag_out(zf),
        .flush_out(flush), .nop_cycle_out(nop));
    // clock at 20 MHz
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end
    // present one word at the falling edge, return after its result edge
    task automatic issue(input logic [11:0] w, input logic [7:0] d);
        valid = 1'b1;
        insn = w;
        rdata = d;
        #1 `CHK(raddr, w[4:0])
        @(negedge clock_in);
    endtask
    task automatic idle();
        valid = 1'b0;
        @(negedge clock_in);
    endtask
    // or literal, zero flag both ways, back to back
    task automatic t_or_lit();
        issue(12'hD00, 8'h00);
        `CHK({acc, zwe, zf}, {8'h00, 2'h3})
        issue(12'hD9A, 8'h00);
        `CHK({acc, zwe, zf}, {8'h9A, 2'h2})
        issue(12'hD35, 8'h00);
        `CHK({acc, zwe, zf, we}, {8'hBF, 3'h4})
        idle();
    endtask
    // or file to file 31 with the accumulator kept, then to the accumulator
    task automatic t_or_file();
        issue(12'h13F, 8'h40);
        `CHK({we, waddr, wdata, acc}, {1'h1, 5'h1F, 8'hFF, 8'hBF})
        `CHK({zwe, zf, flush}, 3'h4)
        issue(12'h103, 8'h40);
        `CHK({acc, zwe, zf, we}, {8'hFF, 3'h4})
        idle();
    endtask
    // increment without skip, flags untouched
    task automatic t_inc_keep();
        zf_in = 1'b1;
        issue(12'h3C2, 8'h41);
        `CHK({acc, zwe, zf, flush, we}, {8'h42, 4'h4})
        issue(12'h3E7, 8'h7F);
        `CHK({we, waddr, wdata, acc, zwe}, {1'h1, 5'h07, 8'h80, 8'h42, 1'h0})
        zf_in = 1'b0;
        idle();
    endtask
    // wrap to zero skips exactly the following word, also across a fetch bubble
    task automatic t_inc_skip();
        issue(12'h3C4, 8'hFF);
        `CHK({acc, flush, nop, we, zwe}, {8'h00, 4'hC})
        issue(12'hD55, 8'h00);
        `CHK({acc, zwe, flush, nop}, {8'h00, 3'h0})
        issue(12'hD55, 8'h00);
        `CHK({acc, zwe}, {8'h55, 1'h1})
        issue(12'h3E9, 8'hFF);
        `CHK({we, waddr, wdata, flush}, {1'h1, 5'h09, 8'h00, 1'h1})
        idle();
        `CHK({nop, flush, we, acc}, {3'h4, 8'h55})
        issue(12'hDAA, 8'h00);
        `CHK({acc, zwe, nop}, {8'h55, 2'h0})
        issue(12'hD0A, 8'h00);
        `CHK({acc, zwe}, {8'h5F, 1'h1})
        idle();
    endtask
    // words outside the three patterns change nothing
    task automatic t_other();
        issue(12'hCFF, 8'h00);
        `CHK({acc, zwe, we, flush}, {8'h5F, 3'h0})
        issue(12'h2BF, 8'hFF);
        `CHK({acc, zwe, we, flush, nop}, {8'h5F, 4'h0})
        idle();
    endtask
    // reset in the middle of a skip clears every registered output and the pending skip
    task automatic t_reset();
        issue(12'h3E1, 8'hFF);
        `CHK({we, wdata, flush, nop, acc}, {1'h1, 8'h00, 2'h3, 8'h5F})
        reset_n_in = 1'b0;
        valid = 1'b0;
        zf_in = 1'b1;
        #1 `CHK({acc, we, waddr, wdata, zwe, zf, flush, nop}, 26'h0)
        repeat (2) @(negedge clock_in);
        zf_in = 1'b0;
        reset_n_in = 1'b1;
        issue(12'h120, 8'h00);
        `CHK({we, waddr, wdata, acc}, {1'h1, 5'h00, 8'h00, 8'h00})
        `CHK({zwe, zf, nop}, 3'h6)
        idle();
    endtask
    task automatic wrap_up();
        if (err_count == 0 && n_checks > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (16) @(negedge clock_in);
        reset_n_in = 1'b1;
        @(negedge clock_in);
        t_or_lit();
        t_or_file();
        t_inc_keep();
        t_inc_skip();
        t_other();
        t_reset();
        wrap_up();
    end
    // watchdog, far beyond the roughly 43 cycles of the tests
    initial
    begin
        #20000;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
